// ---- hw/rcg_regs.svh ----
// Register map, field layout and reset values of the remote input command gate
//
// How it works
// [RULE_01] Remote-active output is high while commands are mapped and remote has control.
// [RULE_02] Commands other than program select act only on a rising edge, if accepted.
// [RULE_03] Program select lines form a binary number weighted 1 to 32, levels only.
// [RULE_04] Start runs only with ready, no error, no e-stop, guard closed, no suspend/halt.
// [RULE_05] Halt edge stops all tasks and commands unconditionally.
// [RULE_06] Suspend edge pauses tasks only while running is high.
// [RULE_07] Resume edge continues only when paused and suspend and halt inputs are low.
// [RULE_08] Clear-fault edge clears e-stop and error when ready is high.
// [RULE_09] After an error the far side must clear the fault before other commands. Halt edges are still accepted while error is high.
// [RULE_10] A command edge failing its condition is not run and flags command rejected.
// [RULE_11] Command rejected has no output line after reset until configured.
// [RULE_12] Default map: commands on inputs 0 to 7, status on outputs 0 to 8.
// [RULE_13] Remote commands work only while virtual I/O is enabled.
// [RULE_14] Each input passes a two-stage synchroniser and yields a one-cycle rise pulse.
`ifndef RCG_REGS_SVH
`define RCG_REGS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define RCG_N_IN        24
`define RCG_N_OUT       16
`define RCG_N_FN        11
`define RCG_N_SIG       8
`define RCG_FLD_W       8
`define RCG_IMAP_WORDS  3
`define RCG_OMAP_WORDS  2
`define RCG_IRQ_W       2

// ****************************************************************
// Byte offsets
// ****************************************************************
`define RCG_OFS_CTRL    8'h00
`define RCG_OFS_STATE   8'h04
`define RCG_OFS_IMAP0   8'h08
`define RCG_OFS_OMAP0   8'h14
`define RCG_OFS_IRQ_ST  8'h1C
`define RCG_OFS_IRQ_EN  8'h20
`define RCG_OFS_IRQ_CLR 8'h24
`define RCG_OFS_INLVL   8'h28

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define RCG_CTRL_VIO    0
`define RCG_CTRL_REMOTE 1
`define RCG_CTRL_RST    2'h0
`define RCG_FLD_ASSIGN  7
`define RCG_IMAP_RST    96'h00878685_84000000_83828180
`define RCG_OMAP_RST    64'h00008885_83828180
`define RCG_FN_START    0
`define RCG_FN_SEL_LO   1
`define RCG_FN_SEL_HI   6
`define RCG_FN_HALT     7
`define RCG_FN_SUSPEND  8
`define RCG_FN_RESUME   9
`define RCG_FN_CLEAR    10
`define RCG_IRQ_ACCEPT  0
`define RCG_IRQ_REJECT  1

`endif

// ---- hw/rcg_pkg.sv ----
// Types shared by the remote input command gate
package rcg_pkg;

   typedef struct packed {
      logic ready;
      logic running;
      logic paused;
      logic error;
      logic estop_active;
      logic guard_open;
      logic estop_clear;
   } rcg_status_type;

   typedef struct packed {
      logic run;
      logic halt;
      logic suspend;
      logic resume;
      logic clear_fault;
   } rcg_cmd_type;

endpackage : rcg_pkg

// ---- hw/rcg_edge_sync.sv ----
// Two-stage input synchroniser with rising-edge pulse per bit
`timescale 1ns/1ps

module rcg_edge_sync #(
   parameter int WIDTH = 24
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] din_i,
   output logic      [WIDTH-1:0] level_o,
   output logic      [WIDTH-1:0] rise_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;

   // ****************************************************************
   // Synchroniser chain
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
               prev_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= din_i[g];
               sync_q[g] <= meta_q[g];
               prev_q[g] <= sync_q[g];
            end
         end
         assign level_o[g] = sync_q[g];
         assign rise_o[g]  = sync_q[g] & ~prev_q[g]; // RULE_14
      end
   endgenerate

endmodule : rcg_edge_sync

// ---- hw/rcg_out_map.sv ----
// Routes status signals onto configurable remote output lines
`timescale 1ns/1ps
`include "rcg_regs.svh"

module rcg_out_map #(
   parameter int N_SIG = 8,
   parameter int N_OUT = 16
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic [N_SIG-1:0]     sig_i,
   input  wire logic [8*N_SIG-1:0]   map_i,
   output logic      [N_OUT-1:0]     out_o
);

   logic [N_OUT-1:0] out_d;

   // ****************************************************************
   // Per-line OR of all signals mapped to it
   // ****************************************************************
   genvar o;
   genvar s;
   generate
      for (o = 0; o < N_OUT; o++) begin : g_out
         logic [N_SIG-1:0] hit_w;
         for (s = 0; s < N_SIG; s++) begin : g_sig
            assign hit_w[s] = sig_i[s] & map_i[8*s+`RCG_FLD_ASSIGN]
                            & (map_i[8*s +: 4] == 4'(o));
         end
         assign out_d[o] = |hit_w;
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_o <= '0;
      end else begin
         out_o <= out_d;
      end
   end

endmodule : rcg_out_map

// ---- hw/rcg_top.sv ----
// Remote input command gate: edge-triggered, condition-gated remote commands
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "rcg_regs.svh"

module rcg_top
   import rcg_pkg::*;
#(
   parameter int N_IN  = `RCG_N_IN,
   parameter int N_OUT = `RCG_N_OUT
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic [N_IN-1:0]       remote_in_i,
   input  wire rcg_status_type        status_i,
   output rcg_cmd_type                cmd_o,
   output logic      [5:0]            program_select_o,
   output logic      [N_OUT-1:0]      remote_out_o,
   output logic                       remote_active_o,
   output logic                       command_rejected_o,
   output logic                       irq_o
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : wmerge

   function automatic logic pick(input logic [7:0] fld, input logic [N_IN-1:0] vec);
      logic r;
      r = 1'b0;
      if (fld[`RCG_FLD_ASSIGN] && (int'(fld[4:0]) < N_IN)) begin
         r = vec[fld[4:0]];
      end
      return r;
   endfunction : pick

   // ****************************************************************
   // Registers and wires
   // ****************************************************************
   logic [1:0]                       ctrl_q;
   logic [8*`RCG_N_FN+7:0]           imap_q;
   logic [8*`RCG_N_SIG-1:0]          omap_q;
   logic [`RCG_IRQ_W-1:0]            irq_st_q;
   logic [`RCG_IRQ_W-1:0]            irq_en_q;
   logic                             ack_q;
   logic [31:0]                      dat_q;
   rcg_cmd_type                      cmd_q;
   logic [5:0]                       prog_q;
   logic                             active_q;
   logic                             rejected_q;
   logic                             irq_q;

   logic [N_IN-1:0]                  in_lvl_w;
   logic [N_IN-1:0]                  in_rise_w;
   logic [`RCG_N_FN-1:0]             fn_lvl_w;
   logic [`RCG_N_FN-1:0]             fn_rise_w;
   logic [`RCG_N_FN-1:0]             fn_asg_w;
   logic [`RCG_N_FN-1:0]             fn_ok_w;
   logic [`RCG_N_FN-1:0]             fn_go_w;
   logic [`RCG_N_FN-1:0]             fn_bad_w;
   logic [5:0]                       prog_w;
   logic                             active_d;
   logic                             accept_w;
   logic                             reject_w;
   logic                             req_w;
   logic                             wr_w;
   logic [7:0]                       adr_w;
   logic [31:0]                      rd_w;
   logic [31:0]                      wr_ctrl_w;
   logic [31:0]                      wr_en_w;
   logic [`RCG_IRQ_W-1:0]            irq_clr_w;
   logic [`RCG_IRQ_W-1:0]            irq_ev_w;
   logic [`RCG_IRQ_W-1:0]            irq_st_d;
   logic [`RCG_N_SIG-1:0]            sig_w;
   logic                             ok_start_w;
   logic [`RCG_N_FN-1:0]             sel_mask_w;

   // Reset images of the map registers, cut per word below
   localparam logic [8*`RCG_N_FN+7:0]  IMAP_RST = `RCG_IMAP_RST;
   localparam logic [8*`RCG_N_SIG-1:0] OMAP_RST = `RCG_OMAP_RST;

   // ****************************************************************
   // Input synchronisation and function selection
   // ****************************************************************
   rcg_edge_sync #(
      .WIDTH   (N_IN)
   ) rcg_edge_sync_inst (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .din_i   (remote_in_i),
      .level_o (in_lvl_w),
      .rise_o  (in_rise_w)
   );

   genvar k;
   generate
      for (k = 0; k < `RCG_N_FN; k++) begin : g_fn
         assign fn_asg_w[k]  = imap_q[8*k+`RCG_FLD_ASSIGN];
         assign fn_lvl_w[k]  = pick(imap_q[8*k +: 8], in_lvl_w) & active_q;
         assign fn_rise_w[k] = pick(imap_q[8*k +: 8], in_rise_w) & active_q; // RULE_01 RULE_02
      end
   endgenerate

   assign prog_w = fn_lvl_w[`RCG_FN_SEL_HI:`RCG_FN_SEL_LO]; // RULE_03

   // ****************************************************************
   // Acceptance conditions
   // ****************************************************************
   assign ok_start_w = status_i.ready & ~status_i.error & ~status_i.estop_active
                     & ~status_i.guard_open & status_i.estop_clear
                     & ~fn_lvl_w[`RCG_FN_SUSPEND] & ~fn_lvl_w[`RCG_FN_HALT]; // RULE_04

   always_comb begin
      fn_ok_w                  = '0;
      fn_ok_w[`RCG_FN_START]   = ok_start_w;
      fn_ok_w[`RCG_FN_HALT]    = 1'b1; // RULE_05
      fn_ok_w[`RCG_FN_SUSPEND] = status_i.running & ~status_i.error; // RULE_06 RULE_09
      fn_ok_w[`RCG_FN_RESUME]  = status_i.paused & ~status_i.error
                               & ~fn_lvl_w[`RCG_FN_SUSPEND]
                               & ~fn_lvl_w[`RCG_FN_HALT]; // RULE_07 RULE_09
      fn_ok_w[`RCG_FN_CLEAR]   = status_i.ready; // RULE_08
   end

   // Program select bits are levels and never form a command
   assign fn_go_w  = fn_rise_w & fn_ok_w;
   assign sel_mask_w = {{(`RCG_N_FN-`RCG_FN_SEL_HI-1){1'b0}},
                        {(`RCG_FN_SEL_HI-`RCG_FN_SEL_LO+1){1'b1}},
                        {`RCG_FN_SEL_LO{1'b0}}};
   assign fn_bad_w = fn_rise_w & ~fn_ok_w & ~sel_mask_w; // RULE_10
   assign accept_w = |fn_go_w;
   assign reject_w = |fn_bad_w;
   assign active_d = ctrl_q[`RCG_CTRL_VIO] & ctrl_q[`RCG_CTRL_REMOTE]
                   & (|fn_asg_w); // RULE_01 RULE_13

   // ****************************************************************
   // Command outputs
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_q      <= '0;
         prog_q     <= '0;
         active_q   <= 1'b0;
         rejected_q <= 1'b0;
      end else begin
         cmd_q.run         <= fn_go_w[`RCG_FN_START]; // RULE_04
         cmd_q.halt        <= fn_go_w[`RCG_FN_HALT]; // RULE_05
         cmd_q.suspend     <= fn_go_w[`RCG_FN_SUSPEND]; // RULE_06
         cmd_q.resume      <= fn_go_w[`RCG_FN_RESUME]; // RULE_07
         cmd_q.clear_fault <= fn_go_w[`RCG_FN_CLEAR]; // RULE_08
         prog_q            <= fn_go_w[`RCG_FN_START] ? prog_w : prog_q;
         active_q          <= active_d;
         rejected_q        <= reject_w | (rejected_q & ~accept_w); // RULE_10
      end
   end

   // ****************************************************************
   // Wishbone slave, one wait state
   // ****************************************************************
   assign req_w     = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr_w      = req_w & wb_we_i;
   assign adr_w     = {wb_adr_i[7:2], 2'b00};
   assign wr_ctrl_w = wmerge({30'h0, ctrl_q}, wb_dat_i, wb_sel_i);
   assign wr_en_w   = wmerge({30'h0, irq_en_q}, wb_dat_i, wb_sel_i);
   assign irq_clr_w = (wr_w && adr_w == `RCG_OFS_IRQ_CLR && wb_sel_i[0])
                    ? wb_dat_i[`RCG_IRQ_W-1:0] : '0;
   assign irq_ev_w  = {reject_w, accept_w};
   assign irq_st_d  = (irq_st_q & ~irq_clr_w) | irq_ev_w;

   assign rd_w =
      (adr_w == `RCG_OFS_CTRL)   ? {30'h0, ctrl_q} :
      (adr_w == `RCG_OFS_STATE)  ? {24'h0, prog_q, rejected_q, active_q} :
      (adr_w == `RCG_OFS_IMAP0)        ? imap_q[31:0] :
      (adr_w == `RCG_OFS_IMAP0 + 8'h04) ? imap_q[63:32] :
      (adr_w == `RCG_OFS_IMAP0 + 8'h08) ? imap_q[95:64] :
      (adr_w == `RCG_OFS_OMAP0)        ? omap_q[31:0] :
      (adr_w == `RCG_OFS_OMAP0 + 8'h04) ? omap_q[63:32] :
      (adr_w == `RCG_OFS_IRQ_ST) ? {30'h0, irq_st_q} :
      (adr_w == `RCG_OFS_IRQ_EN) ? {30'h0, irq_en_q} :
      (adr_w == `RCG_OFS_INLVL)  ? 32'(in_lvl_w) : 32'h0;

   generate
      for (k = 0; k < `RCG_IMAP_WORDS; k++) begin : g_imap
         logic [31:0] new_w;
         assign new_w = wmerge(imap_q[32*k +: 32], wb_dat_i, wb_sel_i);
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               imap_q[32*k +: 32] <= IMAP_RST[32*k +: 32]; // RULE_12
            end else if (wr_w && adr_w == `RCG_OFS_IMAP0 + 8'(4*k)) begin
               imap_q[32*k +: 32] <= new_w;
            end
         end
      end
      for (k = 0; k < `RCG_OMAP_WORDS; k++) begin : g_omap
         logic [31:0] new_w;
         assign new_w = wmerge(omap_q[32*k +: 32], wb_dat_i, wb_sel_i);
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               omap_q[32*k +: 32] <= OMAP_RST[32*k +: 32]; // RULE_11 RULE_12
            end else if (wr_w && adr_w == `RCG_OFS_OMAP0 + 8'(4*k)) begin
               omap_q[32*k +: 32] <= new_w;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q    <= 1'b0;
         dat_q    <= 32'h0;
         ctrl_q   <= `RCG_CTRL_RST;
         irq_en_q <= '0;
         irq_st_q <= '0;
         irq_q    <= 1'b0;
      end else begin
         ack_q    <= req_w;
         dat_q    <= req_w ? rd_w : dat_q;
         ctrl_q   <= (wr_w && adr_w == `RCG_OFS_CTRL) ? wr_ctrl_w[1:0] : ctrl_q;
         irq_en_q <= (wr_w && adr_w == `RCG_OFS_IRQ_EN) ? wr_en_w[1:0] : irq_en_q;
         irq_st_q <= irq_st_d;
         irq_q    <= |(irq_st_d & irq_en_q);
      end
   end

   // ****************************************************************
   // Remote status outputs
   // ****************************************************************
   assign sig_w = {rejected_q, active_q, status_i.estop_clear, status_i.guard_open,
                   status_i.error, status_i.paused, status_i.running, status_i.ready};

   rcg_out_map #(
      .N_SIG   (`RCG_N_SIG),
      .N_OUT   (N_OUT)
   ) rcg_out_map_inst (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .sig_i   (sig_w),
      .map_i   (omap_q),
      .out_o   (remote_out_o)
   );

   assign wb_dat_o           = dat_q;
   assign wb_ack_o           = ack_q;
   assign cmd_o              = cmd_q;
   assign program_select_o   = prog_q;
   assign remote_active_o    = active_q;
   assign command_rejected_o = rejected_q;
   assign irq_o              = irq_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   start_accept_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
      fn_rise_w[`RCG_FN_START] && ok_start_w |=> cmd_q.run && prog_q == $past(prog_w))
      else $error("accepted start did not run");

   start_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
      fn_rise_w[`RCG_FN_START] && !ok_start_w |=> !cmd_q.run && rejected_q)
      else $error("refused start not flagged");

   halt_always_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
      fn_rise_w[`RCG_FN_HALT] |=> cmd_q.halt)
      else $error("halt edge lost");

   suspend_cond_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
      cmd_q.suspend |-> $past(status_i.running))
      else $error("suspend while not running");

   resume_cond_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
      cmd_q.resume |-> $past(status_i.paused) && !$past(fn_lvl_w[`RCG_FN_HALT]))
      else $error("resume outside its condition");

   clear_cond_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
      cmd_q.clear_fault |-> $past(status_i.ready))
      else $error("clear fault without ready");

   inactive_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
      !active_q |=> cmd_q == '0 && !$rose(rejected_q))
      else $error("command taken while remote inactive");

   vio_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
      !ctrl_q[`RCG_CTRL_VIO] |=> !active_q)
      else $error("remote active without virtual io");

   reject_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
      $fell(rst_i) |-> !omap_q[8*7+`RCG_FLD_ASSIGN])
      else $error("command rejected mapped after reset");

   rise_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
      in_rise_w[0] |-> $past(remote_in_i[0], 2) ##1 !in_rise_w[0])
      else $error("edge pulse wrong");

endmodule : rcg_top

// ---- testbench/rcg_seq_model.sv ----
// Sequencer model driving the remote input lines
`timescale 1ns/1ps

module rcg_seq_model (
   input  wire logic        clk_i,
   output logic      [23:0] lines_o
);
   initial lines_o = 24'h000000;

   // Rise, hold, then stay low long enough to separate edges
   task automatic press(input int idx);
      @(posedge clk_i);
      lines_o[idx] <= 1'b1;
      repeat (4) @(posedge clk_i);
      lines_o[idx] <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : press

   task automatic level(input int idx, input logic v);
      @(posedge clk_i);
      lines_o[idx] <= v;
      repeat (4) @(posedge clk_i);
   endtask : level
endmodule : rcg_seq_model

// ---- testbench/remote_input_command_gate_tb_top.sv ----
// Self-checking bench of the remote input command gate
`timescale 1ns/1ps
`include "rcg_regs.svh"

module remote_input_command_gate_tb_top
   import rcg_pkg::*;
;
   logic           clk_i;
   logic           rst_i;
   logic           wb_cyc;
   logic           wb_stb;
   logic           wb_we;
   logic [7:0]     wb_adr;
   logic [31:0]    wb_dat;
   logic [31:0]    wb_dat_o;
   logic           wb_ack_o;
   logic [23:0]    lines;
   rcg_status_type status;
   rcg_cmd_type    cmd;
   logic [5:0]     program_select_o;
   logic [15:0]    remote_out_o;
   logic           remote_active_o;
   logic           command_rejected_o;
   logic           irq_o;
   int             err_count;
   int             tests_run;
   int             cycles;
   int             cnt[5];
   int             ex[5];
   logic [6:0]     bad[5] = '{7'h01, 7'h49, 7'h45, 7'h43, 7'h40};
   localparam logic [6:0] OK = 7'h41;

   rcg_top rcg_top_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .remote_in_i(lines),
      .status_i(status), .cmd_o(cmd), .program_select_o(program_select_o),
      .remote_out_o(remote_out_o), .remote_active_o(remote_active_o),
      .command_rejected_o(command_rejected_o), .irq_o(irq_o)
   );

   rcg_seq_model rcg_seq_model_inst (.clk_i(clk_i), .lines_o(lines));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // ****************************************************************
   // Pulse counting and timeout
   // ****************************************************************
   always @(posedge clk_i) begin
      for (int i = 0; i < 5; i++) if (cmd[i] === 1'b1) cnt[i]++;
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Index 4 run, 3 halt, 2 suspend, 1 resume, 0 clear fault
   task automatic chk_cmd;
      for (int i = 0; i < 5; i++) chk(cnt[i], ex[i]);
   endtask : chk_cmd

   function automatic logic [15:0] exp_out(input logic [6:0] s);
      return {7'h00, s[0], 2'b00, s[1], 1'b0, s[3], s[4], s[5], s[6]};
   endfunction : exp_out

   // ****************************************************************
   // Wishbone classic cycles
   // ****************************************************************
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= w;
      wb_adr <= a;
      wb_dat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h00000000, q);
      chk(q, exp);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic set_st(input logic [6:0] v);
      @(posedge clk_i);
      status <= rcg_status_type'(v);
      repeat (4) @(posedge clk_i);
   endtask : set_st

   task automatic press(input int idx);
      rcg_seq_model_inst.press(idx);
   endtask : press

   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      rst_i = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_dat = 32'h00000000;
      status = rcg_status_type'(7'h00);
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(remote_active_o, 1'b0);
      rd(`RCG_OFS_CTRL, 32'h00000000);
      rd(`RCG_OFS_IMAP0, 32'h83828180);
      rd(`RCG_OFS_OMAP0 + 8'h04, 32'h00008885);
      wr(8'h3C, 32'hFFFFFFFF);
      rd(8'h3C, 32'h00000000);
      set_st(OK);
      chk(remote_out_o, exp_out(OK));
      press(0);
      chk_cmd();
      wr(`RCG_OFS_CTRL, 32'h00000002);
      chk(remote_active_o, 1'b0);
      wr(`RCG_OFS_CTRL, 32'h00000003);
      chk(remote_active_o, 1'b1);
      wr(`RCG_OFS_IRQ_EN, 32'h00000001);
      rcg_seq_model_inst.level(1, 1'b1);
      rcg_seq_model_inst.level(3, 1'b1);
      chk_cmd();
      press(0);
      ex[4]++;
      chk_cmd();
      chk(program_select_o, 6'h05);
      chk(irq_o, 1'b1);
      rd(`RCG_OFS_STATE, 32'h00000015);
      rd(`RCG_OFS_IRQ_ST, 32'h00000001);
      rd(`RCG_OFS_INLVL, 32'h0000000A);
      rcg_seq_model_inst.level(2, 1'b1);
      chk_cmd();
      press(0);
      ex[4]++;
      chk(program_select_o, 6'h07);
      wr(`RCG_OFS_IRQ_CLR, 32'h00000003);
      chk(irq_o, 1'b0);
      rd(`RCG_OFS_IRQ_CLR, 32'h00000000);
      for (int i = 0; i < 5; i++) begin
         set_st(bad[i]);
         press(0);
         chk_cmd();
         chk(command_rejected_o, 1'b1);
         chk(irq_o, i != 0);
         chk(remote_out_o, exp_out(bad[i]));
         press(4);
         ex[3]++;
         chk_cmd();
         chk(command_rejected_o, 1'b0);
      end
      set_st(7'h49);
      press(5);
      chk(command_rejected_o, 1'b1);
      press(7);
      ex[0]++;
      chk_cmd();
      set_st(OK);
      set_st(7'h01);
      press(7);
      chk_cmd();
      chk(command_rejected_o, 1'b1);
      set_st(OK);
      press(5);
      chk_cmd();
      set_st(OK | 7'h20);
      press(5);
      ex[2]++;
      chk_cmd();
      chk(command_rejected_o, 1'b0);
      set_st(7'h51);
      rcg_seq_model_inst.level(5, 1'b1);
      press(6);
      chk_cmd();
      chk(command_rejected_o, 1'b1);
      rcg_seq_model_inst.level(5, 1'b0);
      press(6);
      ex[1]++;
      chk_cmd();
      set_st(OK);
      rcg_seq_model_inst.level(4, 1'b1);
      ex[3]++;
      press(0);
      chk_cmd();
      rcg_seq_model_inst.level(4, 1'b0);
      wr(`RCG_OFS_IRQ_EN, 32'h00000002);
      chk(irq_o, 1'b1);
      wr(`RCG_OFS_IRQ_CLR, 32'h00000002);
      chk(irq_o, 1'b0);
      wr(`RCG_OFS_OMAP0 + 8'h04, 32'h8B8A8885);
      chk(remote_out_o, exp_out(OK) | 16'h0C00);
      wr(`RCG_OFS_IMAP0 + 8'h08, 32'h00888685);
      press(7);
      press(8);
      ex[0]++;
      chk_cmd();
      chk(remote_out_o, exp_out(OK) | 16'h0400);
      wr(`RCG_OFS_CTRL, 32'h00000001);
      chk(remote_active_o, 1'b0);
      chk(remote_out_o, exp_out(OK));
      press(4);
      chk_cmd();
      results();
   end
endmodule : remote_input_command_gate_tb_top
